// [rtl/iccr_regs.sv]
// command and configuration register bank of the interpolator
`timescale 1ns/1ps
`include "iccr_defines.svh"
module iccr_regs (
   input wire logic CLOCK_I,
   input wire logic ARST_N_I,
   input wire logic CE_I,
   input wire logic SPI_SCLK_I,
   input wire logic SPI_CS_N_I,
   input wire logic SPI_MOSI_I,
   output logic SPI_MISO_O,
   input wire logic TRIGGER_PIN_I,
   input wire logic [3:0] HW_ADDRESS_PINS_I,
   input wire logic [1:0] GAIN_PINS_I,
   input wire logic [1:0] FILTER_PINS_I,
   input wire logic CFG_FROM_PIN_I,
   input wire logic BISS_ACTIVE_I,
   input wire logic [6:0] ERR_CLASS_I,
   input wire logic [2:0] QUAD_IN_I,
   input wire logic [1:0] REF_MARK_I,
   input wire logic [1:0] REF_LOST_I,
   input wire logic [31:0] MEAS_VALUE_I,
   input wire logic [15:0] NV_BASE_RATE_I,
   input wire logic [15:0] NV_PITCH_I,
   input wire logic [1:0] CH2_DIV_I,
   output logic [2:0] QUAD_O,
   output logic QUAD_OE_N_O,
   output logic [6:0] ERR_FLAGS_O,
   output logic [3:0] HW_ADDRESS_O,
   output logic CALIB_REFRESH_O,
   output logic OFFSET_PRESET_O,
   output logic NV_SAVE_O,
   output logic DEVICE_RESET_O,
   output logic CTRL_RESET_O,
   output logic COUNTER_RELOAD_O,
   output logic REF_MEASURE_START_O,
   output logic [1:0] REF_PASSED_O,
   output logic COUNTER_MODE_O,
   output logic [31:0] ERROR_AND_SIGNAL_CONFIG_O,
   output logic [31:0] PHASE_READ_REFERENCE_CONFIG_O,
   output logic [7:0] MIN_EDGE_CYCLES_O,
   output logic [15:0] RATE_CH1_O,
   output logic [15:0] RATE_CH2_O,
   output logic [15:0] PITCH_O,
   output logic [31:0] TRIG_HOLD_O
);
   // link side words
   logic wr_tgl; // write word toggle, link clock
   logic [1:0] wr_sel; // register addressed by the write
   logic [31:0] wr_data; // written word, stable per frame
   logic rd_tgl; // read request toggle, link clock
   logic [1:0] rd_sel; // register addressed by the read
   logic ack_tgl_q; // read answer toggle
   logic [31:0] hold_q; // 32-bit read holding register
   // pin synchronisers: trigger, address, gain, filter, source, biss
   logic [10:0] pin_s1_q;
   logic [10:0] pin_s2_q;
   logic trg_s3_q; // third trigger flop for edges
   logic [1:0] tgl_s1_q; // toggle synchronisers {read, write}
   logic [1:0] tgl_s2_q;
   logic [1:0] tgl_s3_q;
   // control state
   logic [1:0] init_cnt_q; // strap load sequencer
   logic [31:0] error_and_signal_config_q; // error and signal configuration
   logic [31:0] phase_read_reference_config_q; // phase, read and reference configuration
   logic [6:0] err_q; // stored or current errors
   logic [1:0] ref_q; // reference passed per channel
   iccr_pkg::iccr_rd_state_t rd_state_q;
   logic [6:0] rd_cnt_q; // synchronous capture delay
   // decoded events
   logic wr_ev;
   logic rd_ev;
   logic [7:0] cmd; // command bits, one cycle, zero if no write
   logic init_load;
   logic trg_edge;
   logic fault;
   logic [15:0] base_rate;
   logic [6:0] det;

   // divide a rate by two to the power n
   function automatic logic [15:0] div_rate(input logic [15:0] r,
         input logic [1:0] n);
      div_rate = r >> n;
   endfunction

   // readback mux shared by both capture paths
   function automatic logic [31:0] reg_read(input logic [1:0] sel,
         input logic [31:0] c1, input logic [31:0] c2,
         input logic [1:0] rf, input logic [6:0] er);
      case (sel)
         `ICCR_SEL_CMD: reg_read = 32'h0000_0000;
         `ICCR_SEL_ERROR_AND_SIGNAL_CONFIG: reg_read = c1;
         `ICCR_SEL_PHASE_READ_REFERENCE_CONFIG: reg_read = c2;
         default: reg_read = {23'h000000, rf, er};
      endcase
   endfunction

   iccr_link u_link (
      .sclk_i(SPI_SCLK_I),
      .arst_n_i(ARST_N_I),
      .cs_n_i(SPI_CS_N_I),
      .mosi_i(SPI_MOSI_I),
      .miso_o(SPI_MISO_O),
      .wr_tgl_o(wr_tgl),
      .wr_sel_o(wr_sel),
      .wr_data_o(wr_data),
      .rd_tgl_o(rd_tgl),
      .rd_sel_o(rd_sel),
      .rd_ack_tgl_i(ack_tgl_q),
      .rd_data_i(hold_q)
   );

   // pins and link toggles pass two flops before use
   always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         pin_s1_q <= 11'h000;
         pin_s2_q <= 11'h000;
         trg_s3_q <= 1'b0;
         tgl_s1_q <= 2'b00;
         tgl_s2_q <= 2'b00;
         tgl_s3_q <= 2'b00;
      end else if (CE_I) begin
         pin_s1_q <= {TRIGGER_PIN_I, HW_ADDRESS_PINS_I, GAIN_PINS_I,
            FILTER_PINS_I, CFG_FROM_PIN_I, BISS_ACTIVE_I};
         pin_s2_q <= pin_s1_q;
         trg_s3_q <= pin_s2_q[10];
         tgl_s1_q <= {rd_tgl, wr_tgl};
         tgl_s2_q <= tgl_s1_q;
         tgl_s3_q <= tgl_s2_q;
      end
   end

   assign wr_ev = CE_I & (tgl_s2_q[0] ^ tgl_s3_q[0]);
   assign rd_ev = CE_I & (tgl_s2_q[1] ^ tgl_s3_q[1]);
   // only bits written as one act, nothing is stored
   assign cmd = (wr_ev && wr_sel == `ICCR_SEL_CMD) ?
      wr_data[7:0] : 8'h00;
   assign init_load = CE_I & (init_cnt_q == `ICCR_INIT_LOAD);
   // rising edge when the slope bit is one, else falling
   assign trg_edge = CE_I & (error_and_signal_config_q[`ICCR_C1_TRIGGER_EDGE_SELECT] ?
      (pin_s2_q[10] & ~trg_s3_q) : (~pin_s2_q[10] & trg_s3_q));
   assign fault = |err_q;
   assign base_rate = error_and_signal_config_q[`ICCR_C1_FIXRATE] ?
      `ICCR_FIXED_RATE : NV_BASE_RATE_I;
   assign det = ERR_CLASS_I & error_and_signal_config_q[22:16];

   // straps wait for the synchronisers; a device reset reruns this
   always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         init_cnt_q <= 2'h0;
      end else if (CE_I) begin
         if (cmd[`ICCR_CMD_DEVRST]) begin
            init_cnt_q <= 2'h0;
         end else if (init_cnt_q != 2'h3) begin
            init_cnt_q <= init_cnt_q + 2'h1;
         end
      end
   end

   // first configuration word
   always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         error_and_signal_config_q <= `ICCR_ERROR_AND_SIGNAL_CONFIG_RST;
      end else if (CE_I) begin
         if (cmd[`ICCR_CMD_DEVRST]) begin
            error_and_signal_config_q <= `ICCR_ERROR_AND_SIGNAL_CONFIG_RST;
         end else if (init_load) begin
            // gain, filter, mode and rate source come from straps
            error_and_signal_config_q[15:14] <= pin_s2_q[5:4];
            error_and_signal_config_q[13:12] <= pin_s2_q[3:2];
            error_and_signal_config_q[`ICCR_C1_QUAD_DET] <= pin_s2_q[1];
            error_and_signal_config_q[`ICCR_C1_FIXRATE] <= pin_s2_q[1];
         end else if (wr_ev && wr_sel == `ICCR_SEL_ERROR_AND_SIGNAL_CONFIG) begin
            error_and_signal_config_q <= wr_data;
         end
      end
   end

   // second configuration word; a write during strap load still lands
   always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         phase_read_reference_config_q <= `ICCR_PHASE_READ_REFERENCE_CONFIG_RST;
      end else if (CE_I) begin
         if (cmd[`ICCR_CMD_DEVRST]) begin
            phase_read_reference_config_q <= `ICCR_PHASE_READ_REFERENCE_CONFIG_RST;
         end else if (wr_ev && wr_sel == `ICCR_SEL_PHASE_READ_REFERENCE_CONFIG) begin
            phase_read_reference_config_q <= wr_data;
         end
      end
   end

   // one-cycle command pulses toward the rest of the device
   always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         CALIB_REFRESH_O <= 1'b0;
         OFFSET_PRESET_O <= 1'b0;
         NV_SAVE_O <= 1'b0;
         DEVICE_RESET_O <= 1'b0;
         CTRL_RESET_O <= 1'b0;
         COUNTER_RELOAD_O <= 1'b0;
         REF_MEASURE_START_O <= 1'b0;
      end else if (CE_I) begin
         CALIB_REFRESH_O <= cmd[`ICCR_CMD_CALIB] | trg_edge;
         OFFSET_PRESET_O <= cmd[`ICCR_CMD_PRESET] &
            phase_read_reference_config_q[`ICCR_C2_PRESET_ENABLE];
         NV_SAVE_O <= cmd[`ICCR_CMD_SAVE];
         DEVICE_RESET_O <= cmd[`ICCR_CMD_DEVRST];
         CTRL_RESET_O <= cmd[`ICCR_CMD_CTLRST];
         COUNTER_RELOAD_O <= cmd[`ICCR_CMD_CNTRLD];
         // adjustment and distance-coded modes share the high bit
         REF_MEASURE_START_O <= (cmd[`ICCR_CMD_CLRREF] |
            cmd[`ICCR_CMD_CNTRLD]) & phase_read_reference_config_q[`ICCR_C2_REF_EVAL_MODE_HI];
      end
   end

   // hardware address latch, by command or at init with biss on
   always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         HW_ADDRESS_O <= 4'h0;
      end else if (cmd[`ICCR_CMD_HWADDR] || (init_load && pin_s2_q[0])) begin
         HW_ADDRESS_O <= pin_s2_q[9:6];
      end
   end

   // trigger holding register
   always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         TRIG_HOLD_O <= 32'h0000_0000;
      end else if (trg_edge) begin
         TRIG_HOLD_O <= MEAS_VALUE_I;
      end
   end

   // errors: detection sets, latch keeps, reload clears; set wins
   always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         err_q <= 7'h00;
      end else if (CE_I) begin
         err_q <= det | (err_q & error_and_signal_config_q[30:24] &
            ~{7{cmd[`ICCR_CMD_CNTRLD]}});
      end
   end

   // reference passed: mark sets, loss or command clears
   always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         ref_q <= 2'b00;
      end else if (CE_I) begin
         ref_q <= REF_MARK_I | (ref_q & ~REF_LOST_I &
            ~{2{cmd[`ICCR_CMD_CLRREF] | cmd[`ICCR_CMD_CNTRLD]}});
      end
   end

   // fault behaviour of the quadrature and index outputs
   always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         QUAD_O <= 3'h0;
         QUAD_OE_N_O <= 1'b1;
      end else if (CE_I) begin
         if (fault && error_and_signal_config_q[`ICCR_C1_TRI]) begin
            QUAD_OE_N_O <= 1'b1;
         end else if (fault && error_and_signal_config_q[`ICCR_C1_HOLD]) begin
            QUAD_OE_N_O <= 1'b0; // level held
         end else begin
            // undefined case simply keeps passing the inputs
            QUAD_OE_N_O <= 1'b0;
            QUAD_O <= QUAD_IN_I;
         end
      end
   end

   // derived settings, registered so outputs come from flops
   always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         MIN_EDGE_CYCLES_O <= 8'h01;
         RATE_CH1_O <= 16'h0000;
         RATE_CH2_O <= 16'h0000;
         PITCH_O <= 16'h0000;
         COUNTER_MODE_O <= 1'b0;
      end else if (CE_I) begin
         MIN_EDGE_CYCLES_O <= 8'h01 << error_and_signal_config_q[7:5];
         RATE_CH1_O <= div_rate(base_rate, error_and_signal_config_q[1:0]);
         RATE_CH2_O <= div_rate(base_rate, error_and_signal_config_q[`ICCR_C1_CH2OWN] ?
            CH2_DIV_I : error_and_signal_config_q[1:0]);
         PITCH_O <= error_and_signal_config_q[`ICCR_C1_FIXRATE] ?
            `ICCR_FIXED_PITCH : NV_PITCH_I;
         COUNTER_MODE_O <= ~error_and_signal_config_q[`ICCR_C1_QUAD_DET];
      end
   end

   // read capture: free capture at once, else after the delay
   always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         rd_state_q <= iccr_pkg::ICCR_RD_IDLE;
         rd_cnt_q <= 7'h00;
         hold_q <= 32'h0000_0000;
         ack_tgl_q <= 1'b0;
      end else if (CE_I) begin
         unique case (rd_state_q)
            iccr_pkg::ICCR_RD_IDLE: begin
               if (rd_ev && phase_read_reference_config_q[`ICCR_C2_FREE_CAPTURE_SELECT]) begin
                  hold_q <= reg_read(rd_sel, error_and_signal_config_q, phase_read_reference_config_q, ref_q,
                     err_q);
                  ack_tgl_q <= ~ack_tgl_q;
                  rd_state_q <= iccr_pkg::ICCR_RD_DONE;
               end else if (rd_ev) begin
                  rd_cnt_q <= phase_read_reference_config_q[14:8];
                  rd_state_q <= iccr_pkg::ICCR_RD_WAIT;
               end
            end
            iccr_pkg::ICCR_RD_WAIT: begin
               if (rd_cnt_q == 7'h00) begin
                  hold_q <= reg_read(rd_sel, error_and_signal_config_q, phase_read_reference_config_q, ref_q,
                     err_q);
                  ack_tgl_q <= ~ack_tgl_q;
                  rd_state_q <= iccr_pkg::ICCR_RD_DONE;
               end else begin
                  rd_cnt_q <= rd_cnt_q - 7'h01;
               end
            end
            iccr_pkg::ICCR_RD_DONE: begin
               rd_state_q <= iccr_pkg::ICCR_RD_IDLE;
            end
            default: begin
               rd_state_q <= iccr_pkg::ICCR_RD_IDLE;
            end
         endcase
      end
   end

   assign ERR_FLAGS_O = err_q;
   assign REF_PASSED_O = ref_q;
   assign ERROR_AND_SIGNAL_CONFIG_O = error_and_signal_config_q;
   assign PHASE_READ_REFERENCE_CONFIG_O = phase_read_reference_config_q;

   // checks on the register bank behaviour
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!ARST_N_I);

   sequence s_cmd(int b);
      CE_I && cmd[b];
   endsequence
   sequence s_sync_read;
      rd_ev && !phase_read_reference_config_q[`ICCR_C2_FREE_CAPTURE_SELECT] && rd_state_q == 2'b00;
   endsequence
   sequence s_answer;
      ack_tgl_q != $past(ack_tgl_q);
   endsequence

   AST_CALIB_PULSE: assert property (
      s_cmd(7) |=> CALIB_REFRESH_O)
      else $error("calibration refresh missing");
   AST_PRESET_GATED: assert property (
      OFFSET_PRESET_O |-> $past(phase_read_reference_config_q[`ICCR_C2_PRESET_ENABLE]))
      else $error("preset without enable");
   AST_HWADDR_LATCH: assert property (
      s_cmd(5) |=> HW_ADDRESS_O == $past(pin_s2_q[9:6]))
      else $error("address pins not latched");
   AST_SAVE_PULSE: assert property (
      s_cmd(4) |=> NV_SAVE_O ##1 !NV_SAVE_O || $past(cmd[4]))
      else $error("save pulse wrong");
   AST_TRISTATE: assert property (
      CE_I && fault && error_and_signal_config_q[`ICCR_C1_TRI] |=> QUAD_OE_N_O)
      else $error("outputs not released on fault");
   AST_LATCH_KEEP: assert property (
      CE_I && err_q[0] && error_and_signal_config_q[24] && !cmd[0] |=> err_q[0])
      else $error("latched error lost");
   AST_EDGE_SPACE: assert property (
      CE_I ##1 CE_I |=> MIN_EDGE_CYCLES_O == 8'h01 << $past(error_and_signal_config_q[7:5]))
      else $error("edge spacing count wrong");
   AST_SYNC_CAPTURE: assert property (
      s_sync_read ##1 CE_I |-> ##[0:128] s_answer)
      else $error("delayed capture never answered");
   AST_REF_CLEAR: assert property (
      (s_cmd(2) and (REF_MARK_I == 2'b00)) |=> ref_q == 2'b00)
      else $error("reference status not cleared");
   AST_CMD_READS_ZERO: assert property (
      (s_answer and (rd_sel == `ICCR_SEL_CMD)) |->
      hold_q == 32'h0000_0000)
      else $error("command register read nonzero");
endmodule

// [rtl/iccr_defines.svh]
// constants for the interpolator command and configuration register bank
`ifndef ICCR_DEFINES_SVH
`define ICCR_DEFINES_SVH
// register select codes carried in the frame header
`define ICCR_SEL_CMD 2'h0
`define ICCR_SEL_ERROR_AND_SIGNAL_CONFIG 2'h1
`define ICCR_SEL_PHASE_READ_REFERENCE_CONFIG 2'h2
`define ICCR_SEL_STATUS 2'h3
// command bits
`define ICCR_CMD_CALIB 7
`define ICCR_CMD_PRESET 6
`define ICCR_CMD_HWADDR 5
`define ICCR_CMD_SAVE 4
`define ICCR_CMD_DEVRST 3
`define ICCR_CMD_CLRREF 2
`define ICCR_CMD_CTLRST 1
`define ICCR_CMD_CNTRLD 0
// first configuration word fields
`define ICCR_C1_TRI 31
`define ICCR_C1_LATCH_LO 24
`define ICCR_C1_HOLD 23
`define ICCR_C1_DETECT_LO 16
`define ICCR_C1_QUAD_DET 19
`define ICCR_C1_GAIN_LO 14
`define ICCR_C1_FILT_LO 12
`define ICCR_C1_TPP_LO 5
`define ICCR_C1_TRIGGER_EDGE_SELECT 4
`define ICCR_C1_FIXRATE 3
`define ICCR_C1_CH2OWN 2
`define ICCR_C1_DIV_LO 0
// second configuration word fields
`define ICCR_C2_PRESET_ENABLE 23
`define ICCR_C2_PHRANGE 22
`define ICCR_C2_FREE_CAPTURE_SELECT 15
`define ICCR_C2_SYNC_LO 8
`define ICCR_C2_REF_EVAL_MODE_HI 7
// reset values before straps are applied
`define ICCR_ERROR_AND_SIGNAL_CONFIG_RST 32'h00f7_0000
`define ICCR_PHASE_READ_REFERENCE_CONFIG_RST 32'h0000_0004
// fixed base rate and pitch
`define ICCR_FIXED_RATE 16'h07d0
`define ICCR_FIXED_PITCH 16'h007d
// core cycle at which straps are taken after reset
`define ICCR_INIT_LOAD 2'h2
`endif

// [rtl/iccr_pkg.sv]
// types shared by the interpolator register bank
`include "iccr_defines.svh"
package iccr_pkg;
   // read capture sequence, gray along idle-wait-done
   typedef enum logic [1:0] {
      ICCR_RD_IDLE = 2'b00,
      ICCR_RD_WAIT = 2'b01,
      ICCR_RD_DONE = 2'b11
   } iccr_rd_state_t;
endpackage

// [rtl/iccr_link.sv]
// serial link front end running on the host's shift clock
`timescale 1ns/1ps
module iccr_link (
   input wire logic sclk_i,
   input wire logic arst_n_i,
   input wire logic cs_n_i,
   input wire logic mosi_i,
   output logic miso_o,
   output logic wr_tgl_o,
   output logic [1:0] wr_sel_o,
   output logic [31:0] wr_data_o,
   output logic rd_tgl_o,
   output logic [1:0] rd_sel_o,
   input wire logic rd_ack_tgl_i,
   input wire logic [31:0] rd_data_i
);
   logic frame_rst_n; // frame ends clear the bit position
   logic [5:0] cnt_q; // bit position within a frame
   logic [7:0] hdr_q; // header byte, msb first
   logic [31:0] shin_q; // incoming data word
   logic [31:0] shout_q; // outgoing read word
   logic [1:0] ack_s_q; // ack toggle synchroniser
   logic [7:0] hdr_d;

   assign frame_rst_n = arst_n_i & ~cs_n_i;
   assign hdr_d = {hdr_q[6:0], mosi_i};
   assign miso_o = shout_q[31];

   // bit counter, saturates so long frames do nothing more
   always_ff @(posedge sclk_i or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         cnt_q <= 6'h00;
      end else if (cnt_q != 6'h3f) begin
         cnt_q <= cnt_q + 6'h01;
      end
   end

   // header and write data shifting
   always_ff @(posedge sclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         hdr_q <= 8'h00;
         shin_q <= 32'h0000_0000;
      end else if (!cs_n_i) begin
         if (cnt_q < 6'h08) begin
            hdr_q <= hdr_d;
         end else begin
            shin_q <= {shin_q[30:0], mosi_i};
         end
      end
   end

   // completed words leave by toggle; the word stays put until
   // the next frame, which the host spaces out
   always_ff @(posedge sclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wr_tgl_o <= 1'b0;
         wr_sel_o <= 2'h0;
         wr_data_o <= 32'h0000_0000;
         rd_tgl_o <= 1'b0;
         rd_sel_o <= 2'h0;
      end else if (!cs_n_i) begin
         if (cnt_q == 6'h07 && !hdr_d[7]) begin
            rd_sel_o <= hdr_d[1:0];
            rd_tgl_o <= ~rd_tgl_o;
         end
         if (cnt_q == 6'h27 && hdr_q[7]) begin
            wr_sel_o <= hdr_q[1:0];
            wr_data_o <= {shin_q[30:0], mosi_i};
            wr_tgl_o <= ~wr_tgl_o;
         end
      end
   end

   // acknowledge from the core, two flops on this clock
   always_ff @(posedge sclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ack_s_q <= 2'b00;
      end else begin
         ack_s_q <= {ack_s_q[0], rd_ack_tgl_i};
      end
   end

   // read word loads at the end of turnaround; all ones if the
   // core has not answered yet
   always_ff @(posedge sclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         shout_q <= 32'h0000_0000;
      end else if (!cs_n_i) begin
         if (cnt_q == 6'h0f) begin
            if (ack_s_q[1] == rd_tgl_o) begin
               shout_q <= rd_data_i;
            end else begin
               shout_q <= 32'hffff_ffff;
            end
         end else if (cnt_q > 6'h0f) begin
            shout_q <= {shout_q[30:0], 1'b0};
         end
      end
   end
endmodule

// [tb/iccr_host_model.sv]
// host controller model driving the serial register link
`timescale 1ns/1ps
module iccr_host_model (
   output logic sclk_o,
   output logic cs_n_o,
   output logic mosi_o,
   input wire logic miso_i
);
   // link idles with the clock low and the frame deselected
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
   end
   // one whole frame: writes run 40 edges, reads 48
   task automatic xfer(input logic [7:0] hdr, input logic [31:0] wd,
         output logic [31:0] rd);
      int n;
      n = hdr[7] ? 40 : 48;
      rd = 32'h0;
      cs_n_o = 1'b0;
      for (int k = 0; k < n; k++) begin
         // data moves only while the clock is low
         mosi_o = (k < 8) ? hdr[7-k] : (hdr[7] && k < 40 && wd[39-k]);
         #16 sclk_o = 1'b1;
         #16;
         // word bits are taken just before each falling edge
         if (k >= 15 && k <= 46) rd = {rd[30:0], miso_i};
         sclk_o = 1'b0;
         // clock stands still while the core captures
         if (k == 7 && !hdr[7]) #200;
      end
      #16 cs_n_o = 1'b1;
      // a released line must not keep showing its last bit
      mosi_o = ~mosi_o;
      #100;
   endtask
endmodule

// [tb/iccr_regs_bench.sv]
// self-checking bench for the command and configuration register bank
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin fails++; \
$display("[FAIL] %s exp %h got %h", nm, e, s); end end
module iccr_regs_bench;
   int fails = 0;
   int n_checks = 0;
   int cyc = 0;
   int ord [8] = '{0, 1, 2, 4, 5, 6, 7, 3}; // device reset goes last
   logic [6:0] ex [8] = '{7'h03, 7'h04, 7'h01, 7'h08, 7'h10, 7'h00,
      7'h20, 7'h40}; // pulses expected per command bit
   logic clk = 0, rst_n = 0, trigger_pin = 0, clr = 0;
   logic [3:0] hw_address_pins = 4'ha;
   logic [1:0] gp = 2'h2, fp = 2'h1, mk = 2'h0, lost = 2'h0;
   logic [6:0] err = 7'h0;
   logic [2:0] qin = 3'h5;
   logic [31:0] meas = 32'h0, rd;
   logic [15:0] nvr = 16'h1000, nvp = 16'h0123;
   logic [1:0] c2d = 2'h3; // own divider for channel 2
   logic sclk, cs_n, mosi, miso, oe_n, cm;
   logic [2:0] qo;
   logic [6:0] flg, p, seen = 7'h0;
   logic [3:0] hwo;
   logic [1:0] refp;
   logic [31:0] c1o, c2o, th;
   logic [7:0] me;
   logic [15:0] r1, r2, pit;
   iccr_host_model i_host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
      .miso_i(miso));
   iccr_regs i_dut (
      .CLOCK_I(clk), .ARST_N_I(rst_n), .CE_I(1'b1),
      .SPI_SCLK_I(sclk), .SPI_CS_N_I(cs_n), .SPI_MOSI_I(mosi),
      .SPI_MISO_O(miso), .TRIGGER_PIN_I(trigger_pin),
      .HW_ADDRESS_PINS_I(hw_address_pins), .GAIN_PINS_I(gp), .FILTER_PINS_I(fp),
      .CFG_FROM_PIN_I(1'b1), .BISS_ACTIVE_I(1'b1), .ERR_CLASS_I(err),
      .QUAD_IN_I(qin), .REF_MARK_I(mk), .REF_LOST_I(lost),
      .MEAS_VALUE_I(meas), .NV_BASE_RATE_I(nvr), .NV_PITCH_I(nvp),
      .CH2_DIV_I(c2d), .QUAD_O(qo), .QUAD_OE_N_O(oe_n),
      .ERR_FLAGS_O(flg), .HW_ADDRESS_O(hwo), .CALIB_REFRESH_O(p[6]),
      .OFFSET_PRESET_O(p[5]), .NV_SAVE_O(p[4]), .DEVICE_RESET_O(p[3]),
      .CTRL_RESET_O(p[2]), .COUNTER_RELOAD_O(p[1]),
      .REF_MEASURE_START_O(p[0]), .REF_PASSED_O(refp),
      .COUNTER_MODE_O(cm), .ERROR_AND_SIGNAL_CONFIG_O(c1o), .PHASE_READ_REFERENCE_CONFIG_O(c2o), .MIN_EDGE_CYCLES_O(me),
      .RATE_CH1_O(r1), .RATE_CH2_O(r2), .PITCH_O(pit), .TRIG_HOLD_O(th)
   );
   // 200 MHz core clock
   always #2.5 clk = ~clk;
   // sticky record of command pulses, since each stands one cycle only
   always @(posedge clk) seen <= clr ? 7'h0 : (seen | p);
   // hang guard: the whole run needs far fewer cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         fails++;
         stop_test();
      end
   end
   // verdict and end of run
   task stop_test;
      if (fails == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // wait whole core cycles, then let the edge settle
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [1:0] s, input logic [31:0] d);
      logic [31:0] x;
      i_host.xfer({6'h20, s}, d, x);
   endtask
   task automatic rdw(input logic [1:0] s, output logic [31:0] d);
      i_host.xfer({6'h00, s}, 32'h0, d);
   endtask
   task automatic clrs;
      @(posedge clk) clr <= 1'b1;
      @(posedge clk) clr <= 1'b0;
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      wt(8);
      `CHK("hw_init", 4'ha, hwo)
      @(posedge clk) hw_address_pins <= 4'h5;
      wr(0, 32'h20); // address latch is the first access
      wt(8);
      `CHK("hw_cmd", 4'h5, hwo)
      rdw(1, rd);
      `CHK("error_and_signal_config_rst", 32'h00ff_9008, rd)
      rdw(2, rd);
      `CHK("phase_read_reference_config_rst", 32'h0000_0004, rd)
      rdw(0, rd);
      `CHK("cmd_rd", 32'h0, rd)
      `CHK("rate_fix", 16'h07d0, r1)
      `CHK("rate2_fix", 16'h07d0, r2)
      `CHK("pitch_fix", 16'h007d, pit)
      `CHK("quad_pass", 3'h5, qo)
      `CHK("oe_idle", 1'b0, oe_n)
      `CHK("cnt_mode", 1'b0, cm)
      // latch abs only, offset detect off, tristate, spacing, divide by 4,
      // channel 2 on its own divider
      wr(1, 32'hc05f_00e6);
      wt(8);
      `CHK("error_and_signal_config_o", 32'hc05f_00e6, c1o)
      `CHK("min_edge", 8'h80, me)
      `CHK("rate1", 16'h0400, r1)
      `CHK("rate2", 16'h0200, r2)
      `CHK("pitch_nv", nvp, pit)
      @(posedge clk) err <= 7'h60;
      @(posedge clk) err <= 7'h00;
      wt(4);
      `CHK("err_latch", 7'h40, flg)
      `CHK("oe_fault", 1'b1, oe_n)
      rdw(3, rd);
      `CHK("status_err", 32'h40, rd)
      wr(0, 32'h01);
      wt(8);
      `CHK("err_clr", 7'h00, flg)
      `CHK("oe_back", 1'b0, oe_n)
      // falling trigger edge captures and refreshes calibration
      clrs();
      @(posedge clk) trigger_pin <= 1'b1;
      wt(8);
      @(posedge clk) meas <= 32'h1234_5678;
      trigger_pin <= 1'b0;
      wt(8);
      `CHK("trig_hold", 32'h1234_5678, th)
      `CHK("trig_cal", 1'b1, seen[6])
      // reference mark sets status, loss clears it
      @(posedge clk) mk <= 2'h2;
      @(posedge clk) mk <= 2'h0;
      wt(3);
      `CHK("ref_set", 2'h2, refp)
      rdw(3, rd);
      `CHK("status_ref", 32'h100, rd)
      @(posedge clk) lost <= 2'h2;
      @(posedge clk) lost <= 2'h0;
      wt(3);
      `CHK("ref_lost", 2'h0, refp)
      // preset enabled, adjustment mode, new strap levels for reset
      wr(2, 32'h0080_0084);
      @(posedge clk) gp <= 2'h1;
      fp <= 2'h3;
      `CHK("phase_read_reference_config_o", 32'h0080_0084, c2o)
      for (int i = 0; i < 8; i++) begin
         clrs();
         wr(0, 32'h1 << ord[i]);
         wt(10);
         `CHK("cmd_pulse", ex[ord[i]], seen)
      end
      rdw(1, rd);
      `CHK("error_and_signal_config_reload", 32'h00ff_7008, rd)
      // reset default holds the outputs on fault and stores nothing
      @(posedge clk) err <= 7'h01;
      @(posedge clk) qin <= 3'h2;
      wt(4);
      `CHK("quad_hold", 3'h5, qo)
      `CHK("err_live", 7'h01, flg)
      @(posedge clk) err <= 7'h00;
      wt(4);
      `CHK("quad_free", 3'h2, qo)
      `CHK("err_unlatched", 7'h00, flg)
      clrs();
      wr(0, 32'h0);
      wt(10);
      `CHK("cmd_zero", 7'h00, seen)
      stop_test();
   end
endmodule
